// file: rtl/latency_cfg_pkg.sv
// shared constants and types for the latency and leveling mode register
package latency_cfg_pkg;
    localparam logic [5:0] latency_and_leveling_config_addr = 6'h02;
    localparam int read_latency_lsb = 0;
    localparam int write_latency_lsb = 3;
    localparam int latency_set_bit = 6;
    localparam int wrlev_bit = 7;
    localparam logic [7:0] cfg_reset_value = 8'h00;
    localparam logic [5:0] bl32_extra_clocks = 6'h08;
    localparam int bl16_align_col_bits = 4;
    localparam int bl32_align_col_bits = 5;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_mrw_level = 3'b010,
        st_blocked = 3'b100
    } mode_state_type;

    typedef struct packed {
        logic valid;
        logic is_write;
        logic [5:0] addr;
        logic [7:0] op;
    } mr_cmd_type;

    typedef struct packed {
        logic valid;
        logic is_write;
        logic bl32;
        logic [9:0] col;
    } col_cmd_type;

    typedef struct packed {
        logic [5:0] read_latency;
        logic [5:0] write_latency;
        logic [5:0] read_to_precharge_clocks;
        logic write_latency_set_select;
        logic write_level_en;
    } timing_type;
endpackage

// file: rtl/latency_decode.sv
// decodes raw latency codes into clock counts
`timescale 1ns/1ps
module latency_decode (
    // raw fields
    input wire logic [7:0] cfg_i,
    input wire logic read_bus_inversion_enable_i,
    input wire logic bl32_i,
    // decoded values
    output latency_cfg_pkg::timing_type timing_o
);
    import latency_cfg_pkg::*;
    logic [2:0] read_code;
    logic [2:0] write_code;
    assign read_code = cfg_i[read_latency_lsb +: 3];
    assign write_code = cfg_i[write_latency_lsb +: 3];

    always_comb begin
        timing_o = '0;
        timing_o.write_latency_set_select = cfg_i[latency_set_bit];
        timing_o.write_level_en = cfg_i[wrlev_bit];
        if (read_bus_inversion_enable_i) begin
            case (read_code)
                3'h0: timing_o.read_latency = 6'h06;
                3'h1: timing_o.read_latency = 6'h0c;
                3'h2: timing_o.read_latency = 6'h10;
                3'h3: timing_o.read_latency = 6'h16;
                3'h4: timing_o.read_latency = 6'h1c;
                3'h5: timing_o.read_latency = 6'h20;
                3'h6: timing_o.read_latency = 6'h24;
                default: timing_o.read_latency = 6'h28;
            endcase
        end else begin
            case (read_code)
                3'h0: timing_o.read_latency = 6'h06;
                3'h1: timing_o.read_latency = 6'h0a;
                3'h2: timing_o.read_latency = 6'h0e;
                3'h3: timing_o.read_latency = 6'h14;
                3'h4: timing_o.read_latency = 6'h18;
                3'h5: timing_o.read_latency = 6'h1c;
                3'h6: timing_o.read_latency = 6'h20;
                default: timing_o.read_latency = 6'h24;
            endcase
        end
        case (read_code)
            3'h4: timing_o.read_to_precharge_clocks = 6'h0a;
            3'h5: timing_o.read_to_precharge_clocks = 6'h0c;
            3'h6: timing_o.read_to_precharge_clocks = 6'h0e;
            3'h7: timing_o.read_to_precharge_clocks = 6'h10;
            default: timing_o.read_to_precharge_clocks = 6'h08;
        endcase
        if (bl32_i) begin
            timing_o.read_to_precharge_clocks =
                timing_o.read_to_precharge_clocks + bl32_extra_clocks;
        end
        if (cfg_i[latency_set_bit]) begin
            case (write_code)
                3'h0: timing_o.write_latency = 6'h04;
                3'h1: timing_o.write_latency = 6'h08;
                3'h2: timing_o.write_latency = 6'h0c;
                3'h3: timing_o.write_latency = 6'h12;
                3'h4: timing_o.write_latency = 6'h16;
                3'h5: timing_o.write_latency = 6'h1a;
                3'h6: timing_o.write_latency = 6'h1e;
                default: timing_o.write_latency = 6'h22;
            endcase
        end else begin
            case (write_code)
                3'h0: timing_o.write_latency = 6'h04;
                3'h1: timing_o.write_latency = 6'h06;
                3'h2: timing_o.write_latency = 6'h08;
                3'h3: timing_o.write_latency = 6'h0a;
                3'h4: timing_o.write_latency = 6'h0c;
                3'h5: timing_o.write_latency = 6'h0e;
                3'h6: timing_o.write_latency = 6'h10;
                default: timing_o.write_latency = 6'h12;
            endcase
        end
    end
endmodule

// file: rtl/latency_mode_register.sv
// latency and write leveling mode register with two set point copies
`timescale 1ns/1ps
module latency_mode_register (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // mode register command from the command decoder
    input latency_cfg_pkg::mr_cmd_type mr_cmd_i,
    // column command for alignment
    input latency_cfg_pkg::col_cmd_type col_cmd_i,
    // set point bits and inversion enable from other mode registers
    input wire logic write_side_set_point_i,
    input wire logic operating_set_point_i,
    input wire logic read_bus_inversion_enable_i,
    // auto precharge read burst end
    input wire logic rd_ap_burst_end_i,
    // mode register read answer
    output logic mrr_valid_o,
    output logic [7:0] mrr_data_o,
    // active timing
    output latency_cfg_pkg::timing_type timing_o,
    output logic leveling_o,
    output logic cmd_blocked_o,
    // aligned column of a read or write burst
    output logic col_valid_o,
    output logic [9:0] col_aligned_o,
    output logic write_col_violation_o,
    // internal precharge start after auto precharge read
    output logic precharge_start_o
);
    import latency_cfg_pkg::*;

    logic [7:0] copy_ff [2];
    mode_state_type state_ff;
    mode_state_type nxt_state;
    timing_type timing_comb;
    logic [7:0] active_cfg;
    logic [5:0] rtp_cnt_ff;
    logic rtp_run_ff;
    logic bl32_last_ff;
    logic hit;
    logic mode_idle;
    logic mrw_take;
    logic mrr_take;
    logic col_take;

    // a layout that overlaps fields or runs past the operand cannot be decoded
    if (read_latency_lsb + 3 > write_latency_lsb || write_latency_lsb + 3 > latency_set_bit
        || latency_set_bit >= wrlev_bit || wrlev_bit > 7) begin : g_bad_fields
        $error("latency field layout does not fit the operand");
    end
    // the alignment masks below are written for 16n and 32n write bursts
    if (bl16_align_col_bits != 4 || bl32_align_col_bits != 5) begin : g_bad_align
        $error("column alignment widths cannot be served");
    end

    assign hit = mr_cmd_i.valid && (mr_cmd_i.addr == latency_and_leveling_config_addr);
    assign active_cfg = copy_ff[operating_set_point_i];
    // while leveling is active only the write that clears it is obeyed
    assign mode_idle = (state_ff == st_idle);
    assign mrw_take = hit && mr_cmd_i.is_write && (mode_idle || !mr_cmd_i.op[wrlev_bit]);
    assign mrr_take = hit && !mr_cmd_i.is_write && mode_idle;
    assign col_take = col_cmd_i.valid && mode_idle;

    latency_decode u_decode (
        .cfg_i(active_cfg),
        .read_bus_inversion_enable_i(read_bus_inversion_enable_i),
        .bl32_i(bl32_last_ff),
        .timing_o(timing_comb)
    );

    // set point copies, written only through the write-side pointer
    generate
        for (genvar g = 0; g < 2; g++) begin : g_copy
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    copy_ff[g] <= cfg_reset_value;
                end else if (mrw_take && (write_side_set_point_i == 1'(g))) begin
                    copy_ff[g] <= mr_cmd_i.op;
                end
            end
        end
    endgenerate

    // a read during leveling is flagged by the state machine and not answered
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mrr_valid_o <= 1'b0;
        end else begin
            mrr_valid_o <= mrr_take;
        end
    end

    // read data holds until the next answered read
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mrr_data_o <= 8'h00;
        end else if (mrr_take) begin
            mrr_data_o <= copy_ff[write_side_set_point_i];
        end
    end

    // leveling state: only a write that clears the bit ends it
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_idle: begin
                if (hit && mr_cmd_i.is_write && mr_cmd_i.op[wrlev_bit]) begin
                    nxt_state = st_mrw_level;
                end
            end
            st_mrw_level, st_blocked: begin
                if (hit && mr_cmd_i.is_write && !mr_cmd_i.op[wrlev_bit]) begin
                    nxt_state = st_idle;
                end else if (mr_cmd_i.valid || col_cmd_i.valid) begin
                    // any other command is an illegal request; flagged, not obeyed
                    nxt_state = st_blocked;
                end
            end
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= st_idle;
            leveling_o <= 1'b0;
            cmd_blocked_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            leveling_o <= (nxt_state != st_idle);
            cmd_blocked_o <= (nxt_state == st_blocked);
        end
    end

    // column alignment; column commands are ignored while leveling
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            col_valid_o <= 1'b0;
            col_aligned_o <= 10'h000;
        end else begin
            col_valid_o <= col_take;
            if (col_take) begin
                if (!col_cmd_i.is_write) begin
                    col_aligned_o <= {col_cmd_i.col[9:2], 2'b00};
                end else if (col_cmd_i.bl32) begin
                    col_aligned_o <= {col_cmd_i.col[9:bl32_align_col_bits], 5'h00};
                end else begin
                    col_aligned_o <= {col_cmd_i.col[9:bl16_align_col_bits], 4'h0};
                end
            end
        end
    end

    // burst length of the last column command picks the precharge delay
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bl32_last_ff <= 1'b0;
        end else if (col_take) begin
            bl32_last_ff <= col_cmd_i.bl32;
        end
    end

    // a write column with col[3:2] nonzero is flagged for one cycle but still served, whatever the burst length
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            write_col_violation_o <= 1'b0;
        end else begin
            write_col_violation_o <= col_take && col_cmd_i.is_write
                && (col_cmd_i.col[3:2] != 2'b00);
        end
    end

    // read-to-precharge counter after an auto precharge read burst
    // a new burst end restarts the count from the active copy
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rtp_cnt_ff <= 6'h00;
            rtp_run_ff <= 1'b0;
            precharge_start_o <= 1'b0;
        end else begin
            precharge_start_o <= 1'b0;
            if (rd_ap_burst_end_i) begin
                rtp_cnt_ff <= timing_comb.read_to_precharge_clocks - 6'h01;
                rtp_run_ff <= 1'b1;
            end else if (rtp_run_ff) begin
                if (rtp_cnt_ff == 6'h01 || rtp_cnt_ff == 6'h00) begin
                    rtp_run_ff <= 1'b0;
                    precharge_start_o <= 1'b1;
                end
                rtp_cnt_ff <= rtp_cnt_ff - 6'h01;
            end
        end
    end

    // decoded latencies in device clocks, registered
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            timing_o <= '0;
        end else begin
            timing_o <= timing_comb;
        end
    end
endmodule

// file: test/latency_mode_register_monitor.sv
// port assertions for the latency mode register
`timescale 1ns/1ps
module latency_mode_register_monitor (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // watched ports
    input latency_cfg_pkg::mr_cmd_type mr_cmd_i,
    input latency_cfg_pkg::col_cmd_type col_cmd_i,
    input wire logic mrr_valid_o,
    input wire logic leveling_o,
    input wire logic cmd_blocked_o,
    input wire logic col_valid_o,
    input wire logic [9:0] col_aligned_o,
    input wire logic write_col_violation_o
);
    import latency_cfg_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic hit;
    logic cw;
    assign hit = mr_cmd_i.valid && mr_cmd_i.addr == latency_and_leveling_config_addr;
    assign cw = col_cmd_i.valid && col_cmd_i.is_write && !leveling_o;
    property p_mrr; hit && !mr_cmd_i.is_write |=> mrr_valid_o != $past(leveling_o); endproperty
    a_mrr: assert property (p_mrr) else $error("mode read unanswered");
    property p_mrr_only;
        mrr_valid_o |-> $past(hit) && !$past(mr_cmd_i.is_write) && !$past(leveling_o);
    endproperty
    a_mrr_only: assert property (p_mrr_only) else $error("stray read answer");
    property p_lev_on; hit && mr_cmd_i.is_write && mr_cmd_i.op[7] |=> leveling_o; endproperty
    a_lev_on: assert property (p_lev_on) else $error("leveling not entered");
    property p_lev_hold;
        leveling_o && !(hit && mr_cmd_i.is_write && !mr_cmd_i.op[7]) |=> leveling_o;
    endproperty
    a_lev_hold: assert property (p_lev_hold) else $error("leveling left early");
    property p_lev_off; hit && mr_cmd_i.is_write && !mr_cmd_i.op[7] |=> !leveling_o; endproperty
    a_lev_off: assert property (p_lev_off) else $error("leveling not left");
    property p_rd_align; col_valid_o |-> col_aligned_o[1:0] == 2'b00; endproperty
    a_rd_align: assert property (p_rd_align) else $error("low column bits set");
    property p_wr16; cw && !col_cmd_i.bl32 |=> col_valid_o && col_aligned_o[3:0] == 4'h0; endproperty
    a_wr16: assert property (p_wr16) else $error("short burst misaligned");
    property p_wr32; cw && col_cmd_i.bl32 |=> col_valid_o && col_aligned_o[4:0] == 5'h00; endproperty
    a_wr32: assert property (p_wr32) else $error("long burst misaligned");
    property p_viol; cw |=> write_col_violation_o == ($past(col_cmd_i.col[3:2]) != 2'b00); endproperty
    a_viol: assert property (p_viol) else $error("violation flag wrong");
    property p_block; col_cmd_i.valid && leveling_o |=> !col_valid_o && cmd_blocked_o; endproperty
    a_block: assert property (p_block) else $error("command not blocked");
endmodule
bind latency_mode_register latency_mode_register_monitor u_mon (.*);

// file: test/mr_ctrl_model.sv
// memory controller model issuing mode and column commands
`timescale 1ns/1ps
module mr_ctrl_model (
    // clock
    input wire logic clk_sys_i,
    // commands toward the device
    output latency_cfg_pkg::mr_cmd_type mr_cmd_o,
    output latency_cfg_pkg::col_cmd_type col_cmd_o,
    output logic rd_ap_burst_end_o
);
    import latency_cfg_pkg::*;
    initial begin
        mr_cmd_o = '0;
        col_cmd_o = '0;
        rd_ap_burst_end_o = 1'b0;
    end
    // each command is a one-cycle pulse, so the device sees it at exactly one edge
    task automatic mrw(input logic w, input logic [5:0] a, input logic [7:0] op);
        @(negedge clk_sys_i);
        mr_cmd_o = '{1'b1, w, a, op};
        @(negedge clk_sys_i);
        mr_cmd_o = '0;
    endtask
    task automatic col(input logic w, input logic b32, input logic [9:0] c);
        @(negedge clk_sys_i);
        col_cmd_o = '{1'b1, w, b32, c};
        @(negedge clk_sys_i);
        col_cmd_o = '0;
    endtask
    task automatic ap_end();
        @(negedge clk_sys_i);
        rd_ap_burst_end_o = 1'b1;
        @(negedge clk_sys_i);
        rd_ap_burst_end_o = 1'b0;
    endtask
endmodule

// file: test/latency_mode_register_tb_top.sv
// self-checking bench for the latency mode register
`timescale 1ns/1ps
module latency_mode_register_tb_top;
    import latency_cfg_pkg::*;
    logic clk_sys_i = 0, rst_i = 1, wsp = 0, osp = 0, rbi = 0, mv, lev, blk, cv, vio, pre;
    logic [7:0] md;
    logic [9:0] ca;
    mr_cmd_type mc;
    col_cmd_type cc;
    logic ap;
    timing_type tm;
    int num_errors = 0, n_compared = 0, b32 = 0, n, x;
    int cp[2] = '{0, 0};
    int read_lat_t[2][8] = '{'{6, 10, 14, 20, 24, 28, 32, 36}, '{6, 12, 16, 22, 28, 32, 36, 40}};
    int write_lat_t[2][8] = '{'{4, 6, 8, 10, 12, 14, 16, 18}, '{4, 8, 12, 18, 22, 26, 30, 34}};
    int rtp_t[8] = '{8, 8, 8, 8, 10, 12, 14, 16};
    logic [7:0] c;
    initial forever #25 clk_sys_i = ~clk_sys_i;
    mr_ctrl_model u_mr_ctrl_model (.clk_sys_i(clk_sys_i), .mr_cmd_o(mc), .col_cmd_o(cc),
        .rd_ap_burst_end_o(ap));
    latency_mode_register u_latency_mode_register (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .mr_cmd_i(mc), .col_cmd_i(cc), .write_side_set_point_i(wsp), .operating_set_point_i(osp),
        .read_bus_inversion_enable_i(rbi), .rd_ap_burst_end_i(ap), .mrr_valid_o(mv),
        .mrr_data_o(md), .timing_o(tm), .leveling_o(lev), .cmd_blocked_o(blk),
        .col_valid_o(cv), .col_aligned_o(ca), .write_col_violation_o(vio),
        .precharge_start_o(pre));
    task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_timing();
        c = 8'(cp[osp]);
        chk("read_latency", 10'(read_lat_t[rbi][c[2:0]]), 10'(tm.read_latency));
        chk("write_latency", 10'(write_lat_t[c[6]][c[5:3]]), 10'(tm.write_latency));
        chk("rtp", 10'(rtp_t[c[2:0]] + 8 * b32), 10'(tm.read_to_precharge_clocks));
        chk("wls", 10'(c[6]), 10'(tm.write_latency_set_select));
        chk("wlev", 10'(c[7]), 10'(tm.write_level_en));
    endtask
    task automatic wr(logic [7:0] op);
        u_mr_ctrl_model.mrw(1'b1, latency_and_leveling_config_addr, op);
        cp[wsp] = op;
        chk("leveling", 10'(op[7]), 10'(lev));
        repeat (2) @(negedge clk_sys_i);
    endtask
    task automatic test_done();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        test_done();
    end
    initial begin
        x = $urandom(18);
        repeat (10) @(negedge clk_sys_i);
        rst_i = 0;
        @(negedge clk_sys_i);
        chk_timing();
        // every code once, then random ones
        for (int i = 0; i < 12; i++) begin
            rbi = i[1];
            x = (i < 8) ? {i[0], 3'(7 - i), 3'(i)} : $urandom_range(0, 127);
            wr(8'(x));
            chk_timing();
        end
        wsp = 1;
        wr(8'h5b);
        chk_timing();
        for (int s = 1; s >= 0; s--) begin
            wsp = s[0];
            u_mr_ctrl_model.mrw(1'b0, latency_and_leveling_config_addr, 8'h00);
            chk("mrr_valid", 10'h001, 10'(mv));
            chk("mrr_data", 10'(cp[s]), 10'(md));
        end
        osp = 1;
        repeat (2) @(negedge clk_sys_i);
        chk_timing();
        for (int k = 0; k < 4; k++) begin
            b32 = (k == 2);
            u_mr_ctrl_model.col(k > 0, k == 2, (k == 3) ? 10'h230 : 10'h3ff);
            chk("col_valid", 10'h001, 10'(cv));
            chk("col", (k == 0) ? 10'h3fc : (k == 1) ? 10'h3f0 : (k == 2) ? 10'h3e0 : 10'h230,
                ca);
            chk("violation", 10'(k == 1 || k == 2), 10'(vio));
            u_mr_ctrl_model.ap_end();
            n = 1;
            while (pre !== 1'b1 && n < 60) begin
                @(negedge clk_sys_i);
                n++;
            end
            chk_timing();
            chk("precharge", 10'(tm.read_to_precharge_clocks), 10'(n));
        end
        wr(8'ha5);
        chk_timing();
        u_mr_ctrl_model.col(1'b0, 1'b0, 10'h010);
        chk("blocked_col", 10'h000, 10'(cv));
        chk("blocked", 10'h001, 10'(blk));
        u_mr_ctrl_model.mrw(1'b0, latency_and_leveling_config_addr, 8'h00);
        chk("blocked_mrr", 10'h000, 10'(mv));
        u_mr_ctrl_model.mrw(1'b1, 6'h03, 8'h00);
        chk("stay", 10'h001, 10'(lev));
        wr(8'h25);
        chk("unblocked", 10'h000, 10'(blk));
        chk_timing();
        // back to the lowest codes, the only band that holds this 20 MHz clock
        wsp = 1;
        wr(8'h00);
        chk_timing();
        test_done();
    end
endmodule
